// >>> oes_top.sv
// exposure slot sequencer with tagged 128-word sample fifo
// Functional notes
// - fifo holds up to 128 samples
// - entries are three bytes with 5-bit tag
// - tag names the producing exposure slot
// - samples pushed in enabled slot order
// - slots stepped ascending, first to sixth
// - first zero slot code ends sequence
// - slot nibbles in three byte registers, reset zero
// - results carry 19 data bits
// - sample rate programmable 8 to 4096 sps
// - low power allowed only at 256 sps or less
// - led drivers: 8-bit code, four ranges
// - pulse width programmable 14.8 to 117.3 us
// - regulator enable low means shutdown
// - gp pin output is open-drain active low
// - decode led, pilot, ambient slot codes
// - normal tags 00001 to 00110 on top bits
// - empty read returns tag 11110
// - picket fence in slots 1 to 3 pushes predicted value, own tag
module oes_top
    import oes_pkg::*;
#(
    // clocks per sample period at the fastest rate
    parameter int SR_CYCLES = OES_CLK_MHZ * 1000000 / OES_SR_MAX_SPS
) (
    input  wire logic                   I_CLK,         // 125 MHz clock
    input  wire logic                   I_SYS_RST,     // sync reset, high
    input  wire logic                   I_CE,          // clock enable
    input  wire logic                   I_REG_WR,      // register write
    input  wire logic [7:0]             I_REG_ADDR,    // register address
    input  wire logic [7:0]             I_REG_WDATA,   // write data
    output logic      [7:0]             O_REG_RDATA,   // read data
    input  wire logic [3:0]             I_SR_SEL,      // rate: 8<<sel sps
    input  wire logic                   I_LOW_POWER,   // low power request
    input  wire logic [1:0]             I_GP_MODE,     // gp pin function
    input  wire logic                   I_GP_OUT_ASSERT, // gp out active
    input  wire logic                   I_GP_IN,       // gp pin level
    output logic                        O_GP_OE,       // gp pin pull low
    output logic                        O_GP_OUT,      // gp pin data
    input  wire logic                   I_REGULATOR_ENABLE_PIN, // pin
    output logic                        O_REGULATOR_ON, // regulator on
    output logic                        O_LOW_POWER_ACTIVE, // powered down
    output logic                        O_EXPO_REQ,    // exposure start
    output logic [3:0]                  O_EXPO_CODE,   // slot code
    output logic [1:0]                  O_EXPO_LED,    // 0 none, 1..3 led
    output logic                        O_EXPO_PILOT,  // pilot exposure
    input  wire logic                   I_CONV_VALID,  // conversion done
    input  wire logic [OES_DATA_W-1:0]  I_CONV_DATA,   // measured sample
    input  wire logic                   I_CONV_PF,     // picket fence hit
    input  wire logic [OES_DATA_W-1:0]  I_CONV_PRED,   // predicted sample
    input  wire logic                   I_FIFO_RD,     // pop a word
    output logic [OES_WORD_W-1:0]       O_FIFO_WORD,   // popped word
    output logic                        O_FIFO_WORD_VALID, // word strobe
    output logic [7:0]                  O_FIFO_COUNT,  // stored words
    input  wire logic [7:0]             I_LED_CODE_1,  // led 1 current code
    input  wire logic [7:0]             I_LED_CODE_2,  // led 2 current code
    input  wire logic [7:0]             I_LED_CODE_3,  // led 3 current code
    input  wire logic [1:0]             I_LED_RANGE_1, // led 1 full scale
    input  wire logic [1:0]             I_LED_RANGE_2, // led 2 full scale
    input  wire logic [1:0]             I_LED_RANGE_3, // led 3 full scale
    input  wire logic [1:0]             I_PULSE_WIDTH, // exposure width
    output logic [7:0]                  O_EXPO_CURRENT, // led current code
    output logic [1:0]                  O_EXPO_RANGE,  // led full scale
    output logic [1:0]                  O_EXPO_WIDTH   // exposure width
);
    import oes_pkg::*;

    // ==========================================================
    // registers
    logic [7:0] slots_reg [3];
    wire        sel_12 = I_REG_ADDR == OES_ADDR_SLOTS_12;
    wire        sel_34 = I_REG_ADDR == OES_ADDR_SLOTS_34;
    wire        sel_56 = I_REG_ADDR == OES_ADDR_SLOTS_56;
    wire  [7:0] rd_mux = sel_12 ? slots_reg[0] : sel_34 ? slots_reg[1] :
                         sel_56 ? slots_reg[2] : 8'h00;
    wire  [3:0] code [OES_NUM_SLOTS];
    genvar g;
    generate
        for (g = 0; g < OES_NUM_SLOTS; g++) begin : g_code
            assign code[g] = (g % 2 == 0) ? slots_reg[g/2][3:0]
                                          : slots_reg[g/2][7:4];
        end
    endgenerate

    // ==========================================================
    // pin synchronisers: three stages, change once last two agree
    logic [2:0] gp_sync_reg, en_sync_reg;
    logic       gp_lvl_reg, en_lvl_reg;
    wire        gp_lvl_next = (gp_sync_reg[1] == gp_sync_reg[2])
                              ? gp_sync_reg[2] : gp_lvl_reg;
    wire        en_lvl_next = (en_sync_reg[1] == en_sync_reg[2])
                              ? en_sync_reg[2] : en_lvl_reg;
    wire        shutdown = ~en_lvl_reg;

    // ==========================================================
    // external sync: low pulse must meet the mode's least width
    logic [13:0] low_cnt_reg;
    logic        sync_fired_reg;
    wire  [13:0] sync_min = (I_GP_MODE == OES_GP_SYNC_SHORT)
                            ? 14'(OES_SYNC_SHORT_CYC)
                            : 14'(OES_SYNC_LONG_CYC);
    wire         sync_mode = (I_GP_MODE == OES_GP_SYNC_SHORT) ||
                             (I_GP_MODE == OES_GP_SYNC_LONG);
    wire         sync_hit = sync_mode && !gp_lvl_reg && !sync_fired_reg &&
                            (low_cnt_reg >= sync_min - 14'd1);

    // ==========================================================
    // sample period timer
    function automatic logic [31:0] period_of(input logic [3:0] sel);
        // sel 0 = 8 sps ... sel 9 = 4096 sps; larger sel held at 9
        period_of = 32'(SR_CYCLES) << (4'd9 - ((sel > 4'd9) ? 4'd9 : sel));
    endfunction
    logic [31:0] tmr_reg;
    wire  [31:0] period = period_of(I_SR_SEL);
    wire         tick = sync_mode ? sync_hit : (tmr_reg == 32'd0);
    // low power only honoured at 256 sps or slower
    wire         lp_ok = I_SR_SEL <= 4'd5;

    // ==========================================================
    // slot sequencer
    oes_state_t  st_reg, st_next;
    logic [2:0]  slot_reg;
    wire  [3:0]  cur_code = code[slot_reg];
    wire         last_slot = (slot_reg == 3'(OES_NUM_SLOTS - 1)) ||
                             (code[slot_reg + 3'd1] == OES_CODE_NONE);
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            OES_IDLE: if (tick && code[0] != OES_CODE_NONE) begin
                st_next = OES_EXPO;
            end
            OES_EXPO: st_next = OES_WAIT;
            OES_WAIT: if (I_CONV_VALID) begin
                st_next = last_slot ? OES_IDLE : OES_EXPO;
            end
            default: st_next = OES_IDLE;
        endcase
    end

    // ==========================================================
    // fifo
    logic [OES_WORD_W-1:0] mem [OES_FIFO_DEPTH];
    logic [6:0]            wp_reg, rp_reg;
    logic [7:0]            cnt_reg;
    wire  [4:0] tag_norm = {2'b00, slot_reg} + 5'd1;
    wire        pf_ok    = I_CONV_PF && slot_reg < 3'd3;
    wire  [4:0] tag      = pf_ok ? OES_TAG_PF_BASE + {2'b00, slot_reg}
                                 : tag_norm;
    wire  [OES_DATA_W-1:0] dat = pf_ok ? I_CONV_PRED : I_CONV_DATA;
    wire        push  = st_reg == OES_WAIT && I_CONV_VALID &&
                        cnt_reg != 8'(OES_FIFO_DEPTH);
    wire        pop   = I_FIFO_RD && cnt_reg != 8'd0;
    wire  [OES_WORD_W-1:0] wr_word = {tag, dat};

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            slots_reg[0] <= OES_SLOT_REG_RST;
            slots_reg[1] <= OES_SLOT_REG_RST;
            slots_reg[2] <= OES_SLOT_REG_RST;
            O_REG_RDATA  <= 8'h00;
        end else if (I_CE) begin
            if (I_REG_WR && sel_12) slots_reg[0] <= I_REG_WDATA;
            if (I_REG_WR && sel_34) slots_reg[1] <= I_REG_WDATA;
            if (I_REG_WR && sel_56) slots_reg[2] <= I_REG_WDATA;
            O_REG_RDATA <= rd_mux;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            gp_sync_reg <= 3'b111;
            en_sync_reg <= 3'b000;
            gp_lvl_reg  <= 1'b1;
            en_lvl_reg  <= 1'b0;
        end else if (I_CE) begin
            gp_sync_reg <= {gp_sync_reg[1:0], I_GP_IN};
            en_sync_reg <= {en_sync_reg[1:0], I_REGULATOR_ENABLE_PIN};
            gp_lvl_reg  <= gp_lvl_next;
            en_lvl_reg  <= en_lvl_next;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            low_cnt_reg    <= 14'd0;
            sync_fired_reg <= 1'b0;
            tmr_reg        <= 32'd0;
        end else if (I_CE) begin
            low_cnt_reg    <= gp_lvl_reg ? 14'd0
                            : (low_cnt_reg == 14'h3fff ? low_cnt_reg
                                                       : low_cnt_reg + 14'd1);
            sync_fired_reg <= gp_lvl_reg ? 1'b0 : (sync_fired_reg | sync_hit);
            tmr_reg        <= (tmr_reg == 32'd0) ? period - 32'd1
                                                 : tmr_reg - 32'd1;
        end
    end

    // shutdown holds the sequencer and empties the fifo
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST || (I_CE && shutdown)) begin
            st_reg   <= OES_IDLE;
            slot_reg <= 3'd0;
            wp_reg   <= 7'd0;
            rp_reg   <= 7'd0;
            cnt_reg  <= 8'd0;
            O_FIFO_WORD       <= 24'h000000;
            O_FIFO_WORD_VALID <= 1'b0;
        end else if (I_CE) begin
            st_reg <= st_next;
            if (st_reg == OES_IDLE) slot_reg <= 3'd0;
            else if (st_reg == OES_WAIT && I_CONV_VALID)
                slot_reg <= slot_reg + 3'd1;
            if (push) begin
                mem[wp_reg] <= wr_word;
                wp_reg <= wp_reg + 7'd1;
            end
            if (pop) rp_reg <= rp_reg + 7'd1;
            cnt_reg <= cnt_reg + 8'(push) - 8'(pop);
            O_FIFO_WORD_VALID <= I_FIFO_RD;
            if (I_FIFO_RD)
                O_FIFO_WORD <= pop ? mem[rp_reg]
                             : {OES_TAG_INVALID, 19'h00000};
        end
    end

    // ==========================================================
    // outputs
    assign O_EXPO_REQ   = st_reg == OES_EXPO;
    assign O_EXPO_CODE  = st_reg == OES_IDLE ? OES_CODE_NONE : cur_code;
    assign O_EXPO_LED   = (cur_code == OES_CODE_LED1 ||
                           cur_code == OES_CODE_PILOT1) ? 2'd1 :
                          (cur_code == OES_CODE_LED2) ? 2'd2 :
                          (cur_code == OES_CODE_LED3) ? 2'd3 : 2'd0;
    assign O_EXPO_PILOT = cur_code == OES_CODE_PILOT1;
    assign O_FIFO_COUNT = cnt_reg;
    assign O_REGULATOR_ON = en_lvl_reg;
    assign O_LOW_POWER_ACTIVE = I_LOW_POWER && lp_ok && st_reg == OES_IDLE;
    // open drain: only ever pulls low
    assign O_GP_OUT = 1'b0;
    assign O_GP_OE  = (I_GP_MODE == OES_GP_OUTPUT) && I_GP_OUT_ASSERT;
    // current and range follow the led the slot picks, ambient drives none; width follows I_PULSE_WIDTH in every slot
    // range 0..3 selects 31, 62, 94 or 124 mA full scale
    assign O_EXPO_CURRENT = (O_EXPO_LED == 2'd1) ? I_LED_CODE_1 :
                            (O_EXPO_LED == 2'd2) ? I_LED_CODE_2 :
                            (O_EXPO_LED == 2'd3) ? I_LED_CODE_3 :
                            8'h00;
    assign O_EXPO_RANGE   = (O_EXPO_LED == 2'd1) ? I_LED_RANGE_1 :
                            (O_EXPO_LED == 2'd2) ? I_LED_RANGE_2 :
                            (O_EXPO_LED == 2'd3) ? I_LED_RANGE_3 :
                            2'd0;
    assign O_EXPO_WIDTH   = st_reg == OES_IDLE ? 2'd0
                                               : I_PULSE_WIDTH;
endmodule

// >>> oes_pkg.sv
// package for the optical exposure sequencer and sample fifo
package oes_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] OES_ADDR_SLOTS_12 = 8'h20;
    localparam logic [7:0] OES_ADDR_SLOTS_34 = 8'h21;
    localparam logic [7:0] OES_ADDR_SLOTS_56 = 8'h22;
    localparam logic [7:0] OES_SLOT_REG_RST  = 8'h00;
    localparam int         OES_NUM_SLOTS     = 6;
    localparam int         OES_CODE_W        = 4;
    // ==========================================================
    // fifo word layout
    localparam int         OES_FIFO_DEPTH    = 128;
    localparam int         OES_DATA_W        = 19;
    localparam int         OES_TAG_W         = 5;
    localparam int         OES_WORD_W        = 24;
    localparam int         OES_TAG_LSB       = 19;
    localparam logic [4:0] OES_TAG_INVALID   = 5'h1e;
    localparam logic [4:0] OES_TAG_PF_BASE   = 5'h0d;
    localparam logic [4:0] OES_TAG_PF_LAST   = 5'h0f;
    // ==========================================================
    // slot codes
    localparam logic [3:0] OES_CODE_NONE     = 4'h0;
    localparam logic [3:0] OES_CODE_LED1     = 4'h1;
    localparam logic [3:0] OES_CODE_LED2     = 4'h2;
    localparam logic [3:0] OES_CODE_LED3     = 4'h3;
    localparam logic [3:0] OES_CODE_PILOT1   = 4'h8;
    localparam logic [3:0] OES_CODE_AMBIENT  = 4'h9;
    // ==========================================================
    // rates and settings
    localparam int         OES_CLK_MHZ       = 125;
    localparam int         OES_SR_MIN_SPS    = 8;
    localparam int         OES_SR_MAX_SPS    = 4096;
    localparam int         OES_LP_MAX_SPS    = 256;
    localparam int         OES_SYNC_SHORT_US = 5;
    localparam int         OES_SYNC_LONG_US  = 64;
    localparam int         OES_SYNC_SHORT_CYC = OES_SYNC_SHORT_US * OES_CLK_MHZ;
    localparam int         OES_SYNC_LONG_CYC  = OES_SYNC_LONG_US * OES_CLK_MHZ;
    localparam logic [1:0] OES_GP_SYNC_SHORT = 2'h2;
    localparam logic [1:0] OES_GP_SYNC_LONG  = 2'h1;
    localparam logic [1:0] OES_GP_OUTPUT     = 2'h3;

    typedef enum logic [1:0] {
        OES_IDLE = 2'b00,
        OES_EXPO = 2'b01,
        OES_WAIT = 2'b10
    } oes_state_t;
endpackage

// >>> oes_checker.sv
// assertion checker for the exposure sequencer ports
module oes_checker
    import oes_pkg::*;
(
    input wire logic        I_CLK, I_SYS_RST, I_CE, I_FIFO_RD,
    input wire logic        I_CONV_VALID, I_REGULATOR_ENABLE_PIN,
    input wire logic        I_GP_OUT_ASSERT, O_GP_OE, O_GP_OUT,
    input wire logic        O_REGULATOR_ON, O_LOW_POWER_ACTIVE,
    input wire logic        O_EXPO_REQ, O_EXPO_PILOT, O_FIFO_WORD_VALID,
    input wire logic [1:0]  I_GP_MODE, O_EXPO_LED,
    input wire logic [3:0]  I_SR_SEL,
    input wire logic [3:0]  O_EXPO_CODE,
    input wire logic [7:0]  O_FIFO_COUNT,
    input wire logic [23:0] O_FIFO_WORD
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    // ====================
    // sequences
    sequence s_slot_done;
        O_EXPO_REQ ##1 (I_CONV_VALID && I_CE && !I_FIFO_RD
            && O_REGULATOR_ON && O_FIFO_COUNT < 8'h80);
    endsequence
    sequence s_empty_pop;
        I_FIFO_RD && I_CE && O_FIFO_COUNT == 8'h00;
    endsequence
    // ====================
    // properties
    chk_push_count: assert property (
        s_slot_done |=> O_FIFO_COUNT == $past(O_FIFO_COUNT) + 8'h01)
        else $error("push not counted");
    chk_empty_tag: assert property (
        s_empty_pop |=> O_FIFO_WORD_VALID
        && O_FIFO_WORD == {OES_TAG_INVALID, 19'h0})
        else $error("empty pop word wrong");
    chk_fifo_depth: assert property (O_FIFO_COUNT <= 8'h80)
        else $error("fifo count above depth");
    chk_no_zero_slot: assert property (
        O_EXPO_REQ |-> O_EXPO_CODE != OES_CODE_NONE)
        else $error("zero slot executed");
    chk_pilot_decode: assert property (
        O_EXPO_REQ && O_EXPO_CODE == OES_CODE_PILOT1
        |-> O_EXPO_LED == 2'h1 && O_EXPO_PILOT)
        else $error("pilot decode wrong");
    chk_led_decode: assert property (
        O_EXPO_REQ && O_EXPO_CODE == OES_CODE_LED2
        |-> O_EXPO_LED == 2'h2 && !O_EXPO_PILOT)
        else $error("led decode wrong");
    chk_ambient_decode: assert property (
        O_EXPO_REQ && O_EXPO_CODE == OES_CODE_AMBIENT
        |-> O_EXPO_LED == 2'h0 && !O_EXPO_PILOT)
        else $error("ambient decode wrong");
    chk_regulator_off: assert property (
        !I_REGULATOR_ENABLE_PIN [*6] |-> !O_REGULATOR_ON)
        else $error("regulator stays on");
    chk_shutdown_idle: assert property (
        !O_REGULATOR_ON && !$past(O_REGULATOR_ON) |-> !O_EXPO_REQ)
        else $error("exposure in shutdown");
    chk_shutdown_flush: assert property (
        !O_REGULATOR_ON [*3] |-> O_FIFO_COUNT == 8'h00)
        else $error("fifo kept in shutdown");
    chk_gp_open_drain: assert property (
        O_GP_OE |-> I_GP_MODE == OES_GP_OUTPUT && I_GP_OUT_ASSERT
        && !O_GP_OUT) else $error("gp pin drive wrong");
    chk_low_power_rate: assert property (
        O_LOW_POWER_ACTIVE |-> I_SR_SEL <= 4'h5)
        else $error("low power above rate");
endmodule

// >>> oes_conv_model.sv
// behavioural conversion engine answering exposure requests
module oes_conv_model (
    input  wire logic        i_clk,   // system clock
    input  wire logic        i_rst,   // sync reset
    input  wire logic        i_req,   // exposure start
    input  wire logic [3:0]  i_code,  // slot code
    input  wire logic        i_pf_en, // report picket fence
    output logic             o_valid, // result strobe
    output logic [18:0]      o_data,  // measured sample
    output logic             o_pf,    // picket fence flag
    output logic [18:0]      o_pred   // predicted sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_reg;
    logic       slow_reg;
    logic [3:0] code_reg;
    // idle lines inverted so stale data never matches
    assign o_data = {15'h2a5a, code_reg} ^ {19{!o_valid}};
    assign o_pred = {15'h1234, code_reg} ^ {19{!o_valid}};
    assign o_pf   = o_valid && i_pf_en;
    // ====================
    // alternate prompt and slow answers
    always_ff @(posedge i_clk) begin
        o_valid <= 1'b0;
        if (i_rst) begin
            cnt_reg  <= 3'h0;
            slow_reg <= 1'b0;
        end else if (i_req) begin
            code_reg <= i_code;
            slow_reg <= !slow_reg;
            cnt_reg  <= slow_reg ? 3'h4 : 3'h0;
            o_valid  <= !slow_reg;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
            o_valid <= cnt_reg == 3'h1;
        end
    end
endmodule

// >>> tb_oes_top.sv
// self-checking bench for the exposure sequencer and fifo
module tb_oes_top
    import oes_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, wr = 0, rd = 0, pin = 1, lp = 0, gpa = 0;
    logic pf = 0, gpi = 1;
    logic [7:0]  addr = 0, wd = 0;
    logic [3:0]  sel = 4'h9;
    logic [1:0]  gpm = 2'h0;
    logic [3:0]  cb [6] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h1, 4'h9};
    wire logic [7:0]  rdata, cnt, cur;
    wire logic [23:0] word;
    wire logic [18:0] cd, cp;
    wire logic [3:0]  code;
    wire logic [1:0]  led, rng, wid;
    wire logic        wv, oe, gpo, ron, lpa, req, pil, cv, cpf;
    int mismatches = 0, checked = 0, n, k = 0;
    always #4 clk = ~clk;
    oes_top #(.SR_CYCLES(20)) u_dut (.I_CLK(clk), .I_SYS_RST(rst),
        .I_CE(1'b1), .I_REG_WR(wr), .I_REG_ADDR(addr), .I_REG_WDATA(wd),
        .O_REG_RDATA(rdata), .I_SR_SEL(sel), .I_LOW_POWER(lp),
        .I_GP_MODE(gpm), .I_GP_OUT_ASSERT(gpa), .I_GP_IN(gpi),
        .O_GP_OE(oe), .O_GP_OUT(gpo), .I_REGULATOR_ENABLE_PIN(pin),
        .O_REGULATOR_ON(ron), .O_LOW_POWER_ACTIVE(lpa), .O_EXPO_REQ(req),
        .O_EXPO_CODE(code), .O_EXPO_LED(led), .O_EXPO_PILOT(pil),
        .I_CONV_VALID(cv), .I_CONV_DATA(cd), .I_CONV_PF(cpf),
        .I_CONV_PRED(cp), .I_FIFO_RD(rd), .O_FIFO_WORD(word),
        .O_FIFO_WORD_VALID(wv), .O_FIFO_COUNT(cnt),
        .I_LED_CODE_1(8'h5a), .I_LED_CODE_2(8'ha5), .I_LED_CODE_3(8'h3c),
        .I_LED_RANGE_1(2'h1), .I_LED_RANGE_2(2'h2), .I_LED_RANGE_3(2'h3),
        .I_PULSE_WIDTH(2'h2), .O_EXPO_CURRENT(cur), .O_EXPO_RANGE(rng),
        .O_EXPO_WIDTH(wid));
    oes_conv_model u_conv (.i_clk(clk), .i_rst(rst), .i_req(req),
        .i_code(code), .i_pf_en(pf), .o_valid(cv), .o_data(cd),
        .o_pf(cpf), .o_pred(cp));
    // ====================
    // tasks
    task automatic check(input string what, input logic [23:0] s, e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clk); wr <= 1'b1; addr <= a; wd <= d;
        @(posedge clk); wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, e);
        @(posedge clk); addr <= a;
        repeat (2) @(posedge clk);
        #1 check("register", {16'h0, rdata}, {16'h0, e});
    endtask
    // bounded wait, a timeout ends the run
    task automatic wait_cnt(input int lo);
        int i;
        for (i = 0; i < 5000 && cnt < lo; i++) @(posedge clk);
        if (i == 5000) begin
            mismatches++;
            tally_and_finish;
        end
    endtask
    task automatic pop(input logic [23:0] e, input int need);
        wait_cnt(need);
        @(posedge clk); rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        #1 check("fifo word", word, e);
        check("word strobe", {23'h0, wv}, 24'h1);
    endtask
    function automatic logic [23:0] ew(int s, logic [3:0] c, bit f);
        return f ? {OES_TAG_PF_BASE + 5'(s), 15'h1234, c}
                 : {5'(s + 1), 15'h2a5a, c};
    endfunction
    // width, range, current and code seen while an exposure is requested
    function automatic logic [23:0] exp_drv(logic [3:0] c);
        case (c)
            4'h1, 4'h8: return {10'h2, 2'h1, 8'h5a, c};
            4'h2:       return {10'h2, 2'h2, 8'ha5, c};
            4'h3:       return {10'h2, 2'h3, 8'h3c, c};
            default:    return {10'h2, 2'h0, 8'h00, c};
        endcase
    endfunction
    // counts exposure requests in k, checking each against slot order
    task automatic count_req(input int cyc);
        logic [23:0] e;
        repeat (cyc) begin
            @(posedge clk);
            if (req === 1'b1) begin
                e = exp_drv(cb[k % 6]);
                // drive word holds the width code
                check("drive", {8'h0, wid, rng, cur, code}, e);
                k++;
            end
        end
    endtask
    // ====================
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (n = 0; n < 4; n++) rd_reg(8'h20 + 8'(n), 8'h00);
        pf <= 1'b1;
        wr_reg(8'h22, 8'h83);
        wr_reg(8'h21, 8'h90);
        wr_reg(8'h20, 8'h21);
        rd_reg(8'h21, 8'h90);
        for (n = 0; n < 6; n++) pop(ew(n % 2, cb[n % 2], 1), 1);
        $display("test stop and picket fence done");
        wr_reg(8'h20, 8'h00);
        pin <= 1'b0;
        repeat (10) @(posedge clk);
        #1 check("shutdown", {15'h0, ron, cnt}, 24'h0);
        @(posedge clk) pin <= 1'b1;
        repeat (10) @(posedge clk);
        pop({OES_TAG_INVALID, 19'h0}, 0);
        $display("test shutdown and empty read done");
        pf <= 1'b0;
        wr_reg(8'h22, 8'h91);
        wr_reg(8'h21, 8'h83);
        wr_reg(8'h20, 8'h21);
        wait_cnt(128);
        repeat (300) @(posedge clk);
        #1 check("fifo full", {16'h0, cnt}, 24'h80);
        for (n = 0; n < 12; n++) pop(ew(n % 6, cb[n % 6], 0), 1);
        $display("test full sequence and overflow done");
        @(posedge clk) lp <= 1'b1;
        repeat (40) @(posedge clk);
        #1 check("low power fast", {23'h0, lpa}, 24'h0);
        @(posedge clk) sel <= 4'h5;
        for (n = 0; n < 400 && lpa !== 1'b1; n++) @(posedge clk);
        check("low power slow", {23'h0, lpa}, 24'h1);
        gpm <= OES_GP_SYNC_SHORT;
        repeat (100) @(posedge clk);
        count_req(300);
        check("idle without sync", 24'(k), 24'h0);
        gpi <= 1'b0;
        count_req(700);
        gpi <= 1'b1;
        count_req(100);
        check("sync sequence", 24'(k), 24'h6);
        $display("test external sync done");
        @(posedge clk) gpm <= OES_GP_OUTPUT;
        gpa <= 1'b1;
        @(posedge clk);
        #1 check("gp pin", {22'h0, oe, gpo}, 24'h2);
        $display("test low power and gp pin done");
        tally_and_finish;
    end
endmodule
bind oes_top oes_checker u_chk (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
    .I_CE(I_CE), .I_FIFO_RD(I_FIFO_RD), .I_CONV_VALID(I_CONV_VALID),
    .I_REGULATOR_ENABLE_PIN(I_REGULATOR_ENABLE_PIN),
    .I_GP_OUT_ASSERT(I_GP_OUT_ASSERT), .O_GP_OE(O_GP_OE),
    .O_GP_OUT(O_GP_OUT), .O_REGULATOR_ON(O_REGULATOR_ON),
    .O_LOW_POWER_ACTIVE(O_LOW_POWER_ACTIVE), .O_EXPO_REQ(O_EXPO_REQ),
    .O_EXPO_PILOT(O_EXPO_PILOT), .O_FIFO_WORD_VALID(O_FIFO_WORD_VALID),
    .I_GP_MODE(I_GP_MODE), .O_EXPO_LED(O_EXPO_LED), .I_SR_SEL(I_SR_SEL),
    .O_EXPO_CODE(O_EXPO_CODE), .O_FIFO_COUNT(O_FIFO_COUNT),
    .O_FIFO_WORD(O_FIFO_WORD));
